/* bbsc_pkg.sv */
// constants, types and decode helpers for the buck-boost switching clock block
package bbsc_pkg;
    // clock and switching frequencies
    localparam int CLK_KHZ = 250000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int FSW0_KHZ = 300;
    localparam int FSW1_KHZ = 400;
    localparam int FSW2_KHZ = 450;
    localparam int PER0 = CLK_KHZ / FSW0_KHZ;
    localparam int PER1 = CLK_KHZ / FSW1_KHZ;
    localparam int PER2 = CLK_KHZ / FSW2_KHZ;
    // external clock windows, shortest period rounds up, longest rounds down
    localparam int WIN0_MIN_KHZ = 250;
    localparam int WIN0_MAX_KHZ = 353;
    localparam int WIN1_MIN_KHZ = 334;
    localparam int WIN1_MAX_KHZ = 470;
    localparam int WIN2_MIN_KHZ = 376;
    localparam int WIN2_MAX_KHZ = 530;
    localparam int LOCK_COUNT = 8;
    // dither
    localparam int DITHER_PCT = 10;
    localparam int DRATE_SLOW_KHZ = 10;
    localparam int DRATE_FAST_KHZ = 25;
    localparam int DPER_SLOW = CLK_KHZ / DRATE_SLOW_KHZ;
    localparam int DPER_FAST = CLK_KHZ / DRATE_FAST_KHZ;
    // soft start
    localparam int SS_TARGET_MV = 5000;
    localparam int CODE_STEP_MV = 20;
    localparam int SS_STEP_NS = 4000;
    localparam int SS_STEP_CYC = (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // widths
    localparam int CNT_W = 11;
    localparam int DSTEP_W = 16;
    localparam int SS_W = 10;
    localparam int VCODE_W = 12;
    localparam int ICODE_W = 7;
    localparam int CTRL_W = 11;
    localparam int ADDR_W = 8;
    localparam logic [VCODE_W-1:0] SS_TARGET_CODE = VCODE_W'(SS_TARGET_MV / CODE_STEP_MV);
    // register map and fields
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_VOUT = 8'h04;
    localparam logic [ADDR_W-1:0] REG_ILIM = 8'h08;
    localparam logic [ADDR_W-1:0] REG_SS = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;
    localparam int SS_START_BIT = 0;
    localparam int STAT_CODE_LSB = 16;
    localparam logic [1:0] FSEL_400 = 2'h1;
    localparam logic [1:0] FSEL_450 = 2'h2;
    localparam logic [1:0] PH_90 = 2'h1;
    localparam logic [1:0] PH_120 = 2'h2;
    localparam int PH120_MUL = 171;
    localparam int PH120_SHIFT = 9;

    typedef struct packed {
        logic ppsContract;
        logic [1:0] droopRange;
        logic droopEn;
        logic [1:0] phaseSel;
        logic syncInMode;
        logic ditherRate;
        logic ditherEn;
        logic [1:0] freqSel;
    } bbsc_ctrl_type;

    // switching low: the four switch bits are forced levels
    typedef struct packed {
        logic switching;
        logic inputHighSwitch;
        logic inputLowSwitch;
        logic outputHighSwitch;
        logic outputLowSwitch;
    } bbsc_gate_type;

    typedef enum logic {SYNC_INTERNAL, SYNC_EXTERNAL} bbsc_sync_type;
    typedef enum logic {SS_IDLE, SS_RAMP} bbsc_ss_type;

    function automatic logic [CNT_W-1:0] nomPeriod(input logic [1:0] sel);
        case (sel)
            FSEL_400: return CNT_W'(PER1);
            FSEL_450: return CNT_W'(PER2);
            default: return CNT_W'(PER0);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] winMin(input logic [1:0] sel);
        case (sel)
            FSEL_400: return CNT_W'((CLK_KHZ + WIN1_MAX_KHZ - 1) / WIN1_MAX_KHZ);
            FSEL_450: return CNT_W'((CLK_KHZ + WIN2_MAX_KHZ - 1) / WIN2_MAX_KHZ);
            default: return CNT_W'((CLK_KHZ + WIN0_MAX_KHZ - 1) / WIN0_MAX_KHZ);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] winMax(input logic [1:0] sel);
        case (sel)
            FSEL_400: return CNT_W'(CLK_KHZ / WIN1_MIN_KHZ);
            FSEL_450: return CNT_W'(CLK_KHZ / WIN2_MIN_KHZ);
            default: return CNT_W'(CLK_KHZ / WIN0_MIN_KHZ);
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] ditherSpan(input logic [1:0] sel);
        return CNT_W'(int'(nomPeriod(sel)) * DITHER_PCT / 100);
    endfunction
endpackage

/* bbsc_sync_src.sv */
// behavioural external clock source on the sync pin, with pin resolution
`timescale 1ns/1ps
`default_nettype none
module bbsc_sync_src (
    input wire logic ref_clk, // bench clock
    input wire logic run, // source makes pulses
    input wire logic [10:0] period, // cycles per pulse
    input wire logic devOut, // device drive level
    input wire logic devOe, // device drive enable
    output logic pin, // level on the sync pin
    output logic [15:0] edges // rising edges made while running
);
    logic [10:0] cnt = '0;
    logic [10:0] perLat = 11'h3e8;
    logic [10:0] curPer;
    logic srcLvl = 1'b0;
    logic newLvl;
    logic [15:0] edgeCnt = '0;
    assign edges = edgeCnt;
    // a new length only takes effect at a pulse start, so no runt period appears
    assign curPer = (cnt == 11'h0) ? period : perLat;
    assign newLvl = run && (cnt != 11'h0) && (cnt <= curPer / 2);
    assign pin = devOe ? devOut : srcLvl;
    // released line flips every cycle so a stale level never passes for a clock
    always @(posedge ref_clk) begin
        if (!run) begin
            cnt <= '0;
            srcLvl <= ~srcLvl;
        end else begin
            cnt <= (cnt + 11'h1 >= curPer) ? 11'h0 : cnt + 11'h1;
            srcLvl <= newLvl;
            edgeCnt <= edgeCnt + 16'(newLvl && !srcLvl);
            if (cnt == 11'h0) begin
                perLat <= period;
            end
        end
    end
endmodule
`default_nettype wire

/* bbsc_top.sv */
// switching clock, dither, sync pin, soft start and switch gating with an apb register file
// Operation
// - switching clock at 300, 400 or 450 kHz
// - dither about ten percent, triangular profile
// - dither rate 10 or 25 kHz
// - sync pin configured as output or input
// - sync output roughly half high, half low
// - sync output carries the same dither
// - sync output delayed 0, 90, 120, 180 degrees
// - lock to external clock inside window only
// - external window depends on nominal frequency
// - relock only after eight good external periods
// - no dither on internal clock in input mode
// - input overvoltage: three switches off, fourth on
// - resume switching once input overvoltage clears
// - 12-bit output voltage code, 20 mV steps
// - soft start ramps code from 0 to 5 V
// - droop compensation, four ranges, off under pps
// - output overvoltage: all off until falling threshold
// - 7-bit current limit code, 50 mA steps
`timescale 1ns/1ps
`default_nettype none
module bbsc_top #(
    parameter int DITHER_SLOW_CYC = bbsc_pkg::DPER_SLOW, // cycles per 10 kHz dither period
    parameter int DITHER_FAST_CYC = bbsc_pkg::DPER_FAST  // cycles per 25 kHz dither period
) (
    input wire logic ref_clk, // 250 MHz clock
    input wire logic rst_n, // synchronous reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [bbsc_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // unmapped address
    input wire logic syncIn, // sync pin level
    output logic syncOut, // sync pin drive level
    output logic syncOe, // sync pin drive enable
    output logic swClk, // internal switching clock
    input wire logic vinOvTrip, // input overvoltage comparator
    input wire logic voutOvRise, // output above rising threshold
    input wire logic voutBelowFall, // output below falling threshold
    output bbsc_pkg::bbsc_gate_type gate, // power switch control
    output logic [bbsc_pkg::VCODE_W-1:0] outputVoltageCode, // voltage dac code
    output logic [bbsc_pkg::ICODE_W-1:0] currentLimitCode, // current dac code
    output logic droopCompEnable, // droop compensation on
    output logic [1:0] droopCompRange // droop compensation range
);
    import bbsc_pkg::*;

    bbsc_ctrl_type ctrl_r;
    logic [VCODE_W-1:0] voutTarget_r;
    logic [VCODE_W-1:0] vcode_r;
    logic [ICODE_W-1:0] ilim_r;
    bbsc_ss_type ss_r;
    logic [SS_W-1:0] ssTick_r;
    logic signed [CNT_W-1:0] dOff_r;
    logic dUp_r;
    logic [DSTEP_W-1:0] dTick_r;
    logic [CNT_W-1:0] swCnt_r;
    logic [CNT_W-1:0] period_r;
    logic [CNT_W-1:0] extCnt_r;
    logic syncPrev_r;
    logic seen_r;
    logic [3:0] good_r;
    bbsc_sync_type sync_r;
    logic voutOv_r;
    logic droopEn_r;
    logic [DSTEP_W-1:0] triCnt_r;
    logic [1:0] triSeen_r;

    // step spacing so 4*span steps fill one modulation period
    function automatic logic [DSTEP_W-1:0] ditherStep(input logic [1:0] sel, input logic rate);
        int per;
        per = rate ? DITHER_FAST_CYC : DITHER_SLOW_CYC;
        return DSTEP_W'(per / (4 * int'(ditherSpan(sel))));
    endfunction

    // apb decode; reads are captured in setup so prdata comes from flops
    wire setupPh = psel & ~penable;
    wire wrEn = psel & penable & pwrite;
    wire hitCtrl = (paddr == REG_CTRL);
    wire hitVout = (paddr == REG_VOUT);
    wire hitIlim = (paddr == REG_ILIM);
    wire hitSs = (paddr == REG_SS);
    wire hitStat = (paddr == REG_STAT);
    wire mapped = hitCtrl | hitVout | hitIlim | hitSs | hitStat;
    wire ssBusy = (ss_r == SS_RAMP);
    wire locked = (sync_r == SYNC_EXTERNAL);
    wire ssStart = wrEn & hitSs & pwdata[SS_START_BIT];
    wire [31:0] statWord = {4'h0, vcode_r, 11'h000, gate.switching, ssBusy, voutOv_r, vinOvTrip, locked};
    wire [31:0] rdMux = hitCtrl ? 32'(ctrl_r) : hitVout ? 32'(voutTarget_r) : hitIlim ? 32'(ilim_r) :
        hitSs ? 32'(ssBusy) : hitStat ? statWord : 32'h0000_0000;

    assign pready = 1'b1;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setupPh) begin
            prdata <= rdMux;
            pslverr <= ~mapped;
        end
    end

    // firmware settings; writes to unmapped words are dropped
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl_r <= '0;
            voutTarget_r <= '0;
            ilim_r <= '0;
        end else if (wrEn) begin
            if (hitCtrl) ctrl_r <= bbsc_ctrl_type'(pwdata[CTRL_W-1:0]);
            if (hitVout) voutTarget_r <= pwdata[VCODE_W-1:0];
            if (hitIlim) ilim_r <= pwdata[ICODE_W-1:0];
        end
    end

    // droop follows firmware but stays off during a pps contract
    always_ff @(posedge ref_clk) begin
        if (!rst_n) droopEn_r <= 1'b0;
        else droopEn_r <= ctrl_r.droopEn & ~ctrl_r.ppsContract;
    end
    assign droopCompEnable = droopEn_r;
    assign droopCompRange = ctrl_r.droopRange;
    assign currentLimitCode = ilim_r;
    assign outputVoltageCode = vcode_r;

    // soft start: monotonic ramp 0 to 5 V code, then firmware code applies
    wire ssStep = (ssTick_r == SS_W'(SS_STEP_CYC - 1));
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ss_r <= SS_IDLE;
            ssTick_r <= '0;
            vcode_r <= '0;
        end else if (ssStart) begin
            ss_r <= SS_RAMP;
            ssTick_r <= '0;
            vcode_r <= '0;
        end else begin
            case (ss_r)
                SS_RAMP: begin
                    ssTick_r <= ssStep ? '0 : ssTick_r + 1'b1;
                    if (vcode_r >= SS_TARGET_CODE) ss_r <= SS_IDLE;
                    else if (ssStep) vcode_r <= vcode_r + 1'b1;
                end
                SS_IDLE: vcode_r <= voutTarget_r;
                default: ss_r <= SS_IDLE;
            endcase
        end
    end

    // triangular dither, never in sync-input mode
    wire ditherOn = ctrl_r.ditherEn & ~ctrl_r.syncInMode;
    wire signed [CNT_W-1:0] spanS = $signed(ditherSpan(ctrl_r.freqSel));
    wire dStep = (dTick_r >= ditherStep(ctrl_r.freqSel, ctrl_r.ditherRate) - 1'b1);
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !ditherOn) begin
            dOff_r <= '0;
            dUp_r <= 1'b1;
            dTick_r <= '0;
        end else if (dStep) begin
            dTick_r <= '0;
            if (dUp_r && dOff_r >= spanS) begin
                dUp_r <= 1'b0;
                dOff_r <= dOff_r - 1'b1;
            end else if (!dUp_r && dOff_r <= -spanS) begin
                dUp_r <= 1'b1;
                dOff_r <= dOff_r + 1'b1;
            end else begin
                dOff_r <= dUp_r ? dOff_r + 1'b1 : dOff_r - 1'b1;
            end
        end else begin
            dTick_r <= dTick_r + 1'b1;
        end
    end

    // top-turn spacing of the triangle; the first two turns after any change are not timed
    wire triTop = dStep && dUp_r && (dOff_r >= spanS);
    wire [DSTEP_W-1:0] rateCyc = DSTEP_W'(ctrl_r.ditherRate ? DITHER_FAST_CYC : DITHER_SLOW_CYC);
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !ditherOn || (wrEn && hitCtrl)) begin
            triCnt_r <= '0;
            triSeen_r <= '0;
        end else if (triTop) begin
            triCnt_r <= '0;
            if (triSeen_r != 2'h2) triSeen_r <= triSeen_r + 1'b1;
        end else begin
            triCnt_r <= triCnt_r + 1'b1;
        end
    end

    // external clock qualifier
    wire extEdge = ctrl_r.syncInMode & syncIn & ~syncPrev_r;
    wire [CNT_W-1:0] wMin = winMin(ctrl_r.freqSel);
    wire [CNT_W-1:0] wMax = winMax(ctrl_r.freqSel);
    wire [CNT_W-1:0] extPer = extCnt_r + 1'b1;
    wire inWin = (extPer >= wMin) && (extPer <= wMax);
    wire timeout = (extCnt_r > wMax);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) syncPrev_r <= 1'b0;
        else syncPrev_r <= syncIn;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || !ctrl_r.syncInMode) begin
            sync_r <= SYNC_INTERNAL;
            good_r <= '0;
            seen_r <= 1'b0;
            extCnt_r <= '0;
        end else if (extEdge) begin
            extCnt_r <= '0;
            seen_r <= 1'b1;
            if (seen_r && inWin && !locked) begin
                good_r <= good_r + 1'b1;
                if (good_r == 4'(LOCK_COUNT - 1)) sync_r <= SYNC_EXTERNAL;
            end else if (seen_r && !inWin) begin
                sync_r <= SYNC_INTERNAL;
                good_r <= '0;
            end
        end else begin
            if (!timeout) extCnt_r <= extCnt_r + 1'b1;
            if (timeout) begin
                sync_r <= SYNC_INTERNAL;
                good_r <= '0;
            end
        end
    end

    // switching counter: restarts on external edges when locked, else free runs;
    // dropping the lock only changes where the current cycle ends, so no runt pulse
    wire [CNT_W-1:0] nomPer = nomPeriod(ctrl_r.freqSel);
    wire cycleEnd = locked ? extEdge : (swCnt_r >= period_r - 1'b1);
    // offset is masked at once, since the dither counter clears one edge late
    wire signed [CNT_W-1:0] dAdd = ditherOn ? dOff_r : '0;
    wire [CNT_W-1:0] nxtPer = (locked && inWin) ? extPer : CNT_W'($signed(nomPer) + dAdd);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            swCnt_r <= '0;
            period_r <= nomPeriod(2'h0);
        end else if (cycleEnd) begin
            swCnt_r <= '0;
            period_r <= nxtPer;
        end else if (swCnt_r != {CNT_W{1'b1}}) begin
            swCnt_r <= swCnt_r + 1'b1;
        end
    end

    // phase-shifted copy of the switching clock; 120 degrees uses a 171/512 scale
    wire [CNT_W-1:0] halfPer = period_r >> 1;
    wire [CNT_W-1:0] ph120 = CNT_W'((32'(period_r) * PH120_MUL) >> PH120_SHIFT);
    wire [CNT_W-1:0] phShift = (ctrl_r.phaseSel == PH_90) ? (period_r >> 2) :
        (ctrl_r.phaseSel == PH_120) ? ph120 : (ctrl_r.phaseSel == 2'h0) ? '0 : halfPer;
    wire [CNT_W:0] shRaw = {1'b0, swCnt_r} + {1'b0, period_r} - {1'b0, phShift};
    wire [CNT_W-1:0] shCnt = (shRaw >= {1'b0, period_r}) ? CNT_W'(shRaw - {1'b0, period_r}) : CNT_W'(shRaw);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            swClk <= 1'b0;
            syncOut <= 1'b0;
            syncOe <= 1'b0;
        end else begin
            swClk <= (swCnt_r < halfPer);
            syncOut <= ~ctrl_r.syncInMode & (shCnt < halfPer);
            syncOe <= ~ctrl_r.syncInMode;
        end
    end

    // overvoltage gating; a new trip wins over the falling-threshold clear
    wire ovNxt = voutOvRise | (voutOv_r & ~voutBelowFall);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            voutOv_r <= 1'b0;
            gate <= '0;
        end else begin
            voutOv_r <= ovNxt;
            if (ovNxt) gate <= '0;
            else if (vinOvTrip) gate <= '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
            else gate <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_vin_hold;
        rst_n && vinOvTrip && !ovNxt |=> !gate.switching && gate.outputLowSwitch && !gate.inputHighSwitch
            && !gate.inputLowSwitch && !gate.outputHighSwitch;
    endproperty
    a_vin_hold: assert property (p_vin_hold) else $error("input overvoltage hold pattern wrong");

    property p_resume;
        rst_n && !vinOvTrip && !ovNxt |=> gate.switching;
    endproperty
    a_resume: assert property (p_resume) else $error("switching not resumed");

    property p_vout_off;
        voutOvRise ##1 !voutBelowFall |-> gate == '0 ##1 gate == '0;
    endproperty
    a_vout_off: assert property (p_vout_off) else $error("switches not held off on output overvoltage");

    property p_lock;
        $rose(locked) |-> $past(good_r) == 4'(LOCK_COUNT - 1) && $past(extEdge) && $past(inWin);
    endproperty
    a_lock: assert property (p_lock) else $error("lock taken without eight good periods");

    property p_fail;
        extEdge && seen_r && !inWin |=> !locked && good_r == '0;
    endproperty
    a_fail: assert property (p_fail) else $error("bad external period kept the lock");

    property p_pin_dir;
        ctrl_r.syncInMode |=> !syncOe && !syncOut;
    endproperty
    a_pin_dir: assert property (p_pin_dir) else $error("sync pin driven in input mode");

    property p_no_dither;
        ctrl_r.syncInMode |=> dOff_r == '0;
    endproperty
    a_no_dither: assert property (p_no_dither) else $error("dither active in sync input mode");

    property p_dither_rate;
        triTop && triSeen_r == 2'h2 |-> triCnt_r < rateCyc && triCnt_r >= rateCyc - (rateCyc >> 2);
    endproperty
    a_dither_rate: assert property (p_dither_rate) else $error("dither triangle period off the rate");

    property p_nominal;
        cycleEnd && !locked && !ditherOn |=> period_r == $past(nomPer);
    endproperty
    a_nominal: assert property (p_nominal) else $error("period differs from nominal setting");

    property p_ss_ramp;
        ssStart ##1 ssBusy |-> vcode_r == '0 ##1 vcode_r <= 12'(1);
    endproperty
    a_ss_ramp: assert property (p_ss_ramp) else $error("soft start did not begin at zero");

    property p_ss_mono;
        ssBusy && !ssStart |=> vcode_r >= $past(vcode_r);
    endproperty
    a_ss_mono: assert property (p_ss_mono) else $error("soft start ramp not monotonic");

    c_lock: cover property ($rose(locked));
    c_fallback: cover property (locked ##1 !locked);
    c_ss_done: cover property (ssBusy ##1 !ssBusy);
    c_vin_hold: cover property (vinOvTrip && !ovNxt ##1 gate.outputLowSwitch);
endmodule
`default_nettype wire

/* tb.sv */
// self-checking bench: apb traffic, sync pin source, clock, dither and gating checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errorCnt++; \
    $display("mismatch %s expected %0d seen %0d", nm, exp, got); end end
module tb;
    import bbsc_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, syncLine, syncOut, syncOe, swClk, droopCompEnable;
    logic vinOvTrip = 1'b0, voutOvRise = 1'b0, voutBelowFall = 1'b0;
    logic srcRun = 1'b0, cmpSync = 1'b0, ssMon = 1'b0;
    bbsc_gate_type gate;
    logic [VCODE_W-1:0] outputVoltageCode, lastCode = '0;
    logic [ICODE_W-1:0] currentLimitCode;
    logic [1:0] droopCompRange;
    logic [10:0] srcPeriod = 11'h3e8;
    logic [15:0] srcEdges;
    int errorCnt = 0, checked = 0, syncDiff = 0, ssBad = 0, p, h, c, lo, hi;
    int nomP [3] = '{PER0, PER1, PER2};
    int minP [3] = '{(CLK_KHZ + WIN0_MAX_KHZ - 1) / WIN0_MAX_KHZ, (CLK_KHZ + WIN1_MAX_KHZ - 1) / WIN1_MAX_KHZ,
                     (CLK_KHZ + WIN2_MAX_KHZ - 1) / WIN2_MAX_KHZ};
    int maxP [3] = '{CLK_KHZ / WIN0_MIN_KHZ, CLK_KHZ / WIN1_MIN_KHZ, CLK_KHZ / WIN2_MIN_KHZ};
    int phD [4] = '{PER0, PER0 / 4, (PER0 * PH120_MUL) >> PH120_SHIFT, PER0 / 2};
    logic [2:0] ovIn [6] = '{3'h4, 3'h0, 3'h2, 3'h4, 3'h5, 3'h0};
    logic [4:0] ovExp [6] = '{5'h01, 5'h10, 5'h00, 5'h00, 5'h01, 5'h10};

    bbsc_top #(.DITHER_SLOW_CYC(2000), .DITHER_FAST_CYC(800)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .syncIn(syncLine), .syncOut(syncOut), .syncOe(syncOe),
        .swClk(swClk), .vinOvTrip(vinOvTrip), .voutOvRise(voutOvRise), .voutBelowFall(voutBelowFall),
        .gate(gate), .outputVoltageCode(outputVoltageCode), .currentLimitCode(currentLimitCode),
        .droopCompEnable(droopCompEnable), .droopCompRange(droopCompRange));
    bbsc_sync_src i_src (.ref_clk(ref_clk), .run(srcRun), .period(srcPeriod), .devOut(syncOut),
        .devOe(syncOe), .pin(syncLine), .edges(srcEdges));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // phase-0 sync pin tracks the clock; the ramp never steps back or skips
    always @(posedge ref_clk) begin
        if (cmpSync && syncLine !== swClk) begin
            syncDiff++;
        end
        if (ssMon && (outputVoltageCode < lastCode || outputVoltageCode > lastCode + 12'h001)) begin
            ssBad++;
        end
        lastCode <= outputVoltageCode;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, errorCnt);
        if (errorCnt == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic stall(input string what);
        errorCnt++;
        $display("mismatch %s expected done seen timeout", what);
        conclude();
    endtask
    // one transfer, entered just after a rising edge; an idle cycle follows
    task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n >= 64) stall("pready");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    // w 0 watches the switching clock, 1 the sync pin
    task automatic lvlWait(input int w, input logic lvl, output int n);
        n = 0;
        while (((w == 0) ? swClk : syncLine) !== lvl && n < 5000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 5000) stall("level");
    endtask
    task automatic measure(input int w);
        lvlWait(w, 1'b0, c);
        lvlWait(w, 1'b1, c);
        lvlWait(w, 1'b0, h);
        lvlWait(w, 1'b1, c);
        p = h + c;
    endtask
    task automatic edgesWait(input int n);
        int tgt;
        int k;
        tgt = int'(srcEdges) + n;
        k = 0;
        while (int'(srcEdges) < tgt && k < n * 1200) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= n * 1200) stall("edges");
        repeat (4) @(posedge ref_clk);
        apb(REG_STAT, 1'b0, '0);
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        `CHK("gate", 5'h10, gate)
        apb(REG_CTRL, 1'b0, '0);
        `CHK("ctrl", 32'h0000_0000, rd)
        apb(8'h14, 1'b0, '0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        apb(REG_ILIM, 1'b1, 32'hffff_ffff); // firmware owns peak limit pairing and uv threshold
        apb(REG_VOUT, 1'b1, 32'hffff_ffff);
        repeat (3) @(posedge ref_clk);
        `CHK("ilim code", 7'h7f, currentLimitCode)
        `CHK("vout code", 12'hfff, outputVoltageCode)
        apb(REG_VOUT, 1'b0, '0);
        `CHK("vout read", 32'h0000_0fff, rd)
        for (int r = 0; r < 4; r++) begin
            apb(REG_CTRL, 1'b1, 32'h0000_0080 | (32'(r) << 8));
            repeat (3) @(posedge ref_clk);
            `CHK("droop en", 1'b1, droopCompEnable)
            `CHK("droop range", 2'(r), droopCompRange)
        end
        apb(REG_CTRL, 1'b1, 32'h0000_0780);
        repeat (3) @(posedge ref_clk);
        `CHK("droop pps", 1'b0, droopCompEnable)
        for (int k = 0; k < 6; k++) begin
            {vinOvTrip, voutOvRise, voutBelowFall} <= ovIn[k];
            repeat (3) @(posedge ref_clk);
            `CHK("gate", ovExp[k], gate)
        end
        $display("test registers and gating done");
        for (int f = 0; f < 3; f++) begin
            apb(REG_CTRL, 1'b1, 32'(f));
            measure(0);
            measure(0);
            `CHK("sw period", nomP[f], p)
            measure(1);
            `CHK("sync period", nomP[f], p)
            `CHK("sync high", nomP[f] / 2, h)
            `CHK("sync oe", 1'b1, syncOe)
        end
        for (int ph = 0; ph < 4; ph++) begin
            apb(REG_CTRL, 1'b1, 32'(ph) << 5);
            measure(0);
            lvlWait(0, 1'b0, c);
            lvlWait(0, 1'b1, c);
            lvlWait(1, 1'b0, c);
            lvlWait(1, 1'b1, h);
            `CHK("sync phase", phD[ph], c + h)
        end
        for (int r = 0; r < 2; r++) begin
            apb(REG_CTRL, 1'b1, 32'h0000_0004 | (32'(r) << 3));
            measure(0);
            cmpSync = 1'b1;
            lo = 5000;
            hi = 0;
            for (int k = 0; k < 6; k++) begin
                measure(0);
                lo = (p < lo) ? p : lo;
                hi = (p > hi) ? p : hi;
            end
            cmpSync = 1'b0;
            `CHK("dither floor", 1'b1, lo >= PER0 - PER0 * DITHER_PCT / 100)
            `CHK("dither ceiling", 1'b1, hi <= PER0 + PER0 * DITHER_PCT / 100)
            `CHK("dither moves", 1'b1, hi > lo)
        end
        `CHK("sync follows", 0, syncDiff)
        $display("test output mode done");
        for (int f = 0; f < 3; f++) begin
            srcRun <= 1'b0;
            apb(REG_CTRL, 1'b1, 32'h0000_0014 | 32'(f));
            @(posedge ref_clk);
            `CHK("sync oe", 1'b0, syncOe)
            srcPeriod <= 11'(minP[f]);
            srcRun <= 1'b1;
            edgesWait(8);
            `CHK("early lock", 1'b0, rd[0])
            edgesWait(1);
            `CHK("lock", 1'b1, rd[0])
            measure(0);
            `CHK("ext period", minP[f], p)
            srcPeriod <= 11'(maxP[f] + 1);
            edgesWait(2);
            `CHK("long drop", 1'b0, rd[0])
            measure(0);
            measure(0);
            `CHK("fallback period", nomP[f], p)
            srcPeriod <= 11'(maxP[f]);
            edgesWait(8);
            `CHK("relock early", 1'b0, rd[0])
            edgesWait(1);
            `CHK("relock", 1'b1, rd[0])
            srcPeriod <= 11'(minP[f] - 1);
            edgesWait(2);
            `CHK("short drop", 1'b0, rd[0])
        end
        srcRun <= 1'b0;
        $display("test input mode done");
        apb(REG_SS, 1'b1, 32'h0000_0001);
        apb(REG_STAT, 1'b0, '0);
        `CHK("ramp busy", 1'b1, rd[3])
        ssMon = 1'b1;
        repeat (10500) @(posedge ref_clk);
        ssMon = 1'b0;
        `CHK("ramp code", 12'h00a, outputVoltageCode)
        `CHK("ramp steps", 0, ssBad)
        apb(REG_STAT, 1'b0, '0);
        `CHK("stat code", 12'h00a, rd[27:16])
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        `CHK("code reset", 12'h000, outputVoltageCode)
        rst_n <= 1'b1;
        $display("test soft start done");
        conclude();
    end
endmodule
`default_nettype wire
